// *** design/sasp_top.sv ***
// Stereo audio serial port: DMA queues, prescalers, channel sequencer, shifter
//
// Summary of operation
// - Inter-IC sound or MSB-justified framing selectable
// - Queues serviced by DMA requests only
// - Transmit and receive independently or together
// - Eight or sixteen bits per channel
// - Two 64-byte queues, transmit and receive
// - Bus writes transmit, reads receive queue
// - State machine governs receive bus and queue access
// - Two 5-bit prescalers: master and codec
// - Master bit clock from prescaled master clock
// - Channel sequencer makes bit and select clocks
// - 16-bit shifter serialises and assembles samples
// - Exactly one stereo port, DMA operated
`timescale 1ns/1ps
module sasp_top #(
  parameter int FIFO_DEPTH = sasp_pkg::SASP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Static configuration
  input wire sasp_pkg::sasp_cfg_t cfg,
  // Transmit DMA
  output logic tx_dma_req,
  input wire logic tx_dma_ack,
  input wire logic [sasp_pkg::SASP_SAMPLE_W-1:0] tx_dma_data,
  // Receive DMA
  output logic rx_dma_req,
  input wire logic rx_dma_ack,
  output logic [sasp_pkg::SASP_SAMPLE_W-1:0] rx_dma_data,
  // Codec link
  output sasp_pkg::sasp_ser_t ser,
  input wire logic sdi
);
  import sasp_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  typedef enum logic [1:0] {BF_IDLE, BF_FETCH, BF_HOLD} sasp_bus_st_t;
  typedef enum logic {CH_IDLE, CH_RUN} sasp_ch_st_t;

  // Queues
  logic tx_push, tx_pop, tx_full, tx_empty;
  logic rx_push, rx_pop, rx_full, rx_empty;
  logic [SASP_SAMPLE_W-1:0] tx_q_data, rx_q_data, rx_push_data;
  logic [CW-1:0] tx_count, rx_count;

  sasp_fifo #(.W(SASP_SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_transmit_queue (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .push(tx_push),
    .push_data(tx_dma_data),
    .pop(tx_pop),
    .pop_data(tx_q_data),
    .full(tx_full),
    .empty(tx_empty),
    .count(tx_count)
  );

  sasp_fifo #(.W(SASP_SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_receive_queue (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .push(rx_push),
    .push_data(rx_push_data),
    .pop(rx_pop),
    .pop_data(rx_q_data),
    .full(rx_full),
    .empty(rx_empty),
    .count(rx_count)
  );

  // Bus and queue control state machine
  sasp_bus_st_t bus_st_ff, nxt_bus_st;
  logic tx_req_ff, nxt_tx_req, rx_req_ff, nxt_rx_req;
  logic [SASP_SAMPLE_W-1:0] rx_data_ff, nxt_rx_data;

  always_comb begin
    nxt_bus_st = bus_st_ff;
    nxt_rx_req = rx_req_ff;
    nxt_rx_data = rx_data_ff;
    rx_pop = 1'b0;
    tx_push = tx_dma_ack && tx_req_ff;
    nxt_tx_req = cfg.tx_en && ((tx_count + CW'(tx_push)) < CW'(FIFO_DEPTH));
    case (bus_st_ff)
      BF_IDLE: begin
        if (cfg.rx_en && !rx_empty) begin
          nxt_bus_st = BF_FETCH;
        end
      end
      BF_FETCH: begin
        rx_pop = 1'b1;
        nxt_rx_data = rx_q_data;
        nxt_rx_req = 1'b1;
        nxt_bus_st = BF_HOLD;
      end
      BF_HOLD: begin
        if (rx_dma_ack) begin
          nxt_rx_req = 1'b0;
          nxt_bus_st = BF_IDLE;
        end
      end
      default: begin
        nxt_bus_st = BF_IDLE;
        nxt_rx_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_st_ff <= BF_IDLE;
      tx_req_ff <= 1'b0;
      rx_req_ff <= 1'b0;
      rx_data_ff <= '0;
    end else begin
      bus_st_ff <= nxt_bus_st;
      tx_req_ff <= nxt_tx_req;
      rx_req_ff <= nxt_rx_req;
      rx_data_ff <= nxt_rx_data;
    end
  end

  assign tx_dma_req = tx_req_ff;
  assign rx_dma_req = rx_req_ff;
  assign rx_dma_data = rx_data_ff;

  // Dual prescaler
  logic [SASP_PRESC_W-1:0] mdiv_ff, nxt_mdiv, cdiv_ff, nxt_cdiv;
  logic codec_clk_ff, nxt_codec_clk, mtick;

  always_comb begin
    mtick = (mdiv_ff >= cfg.master_div);
    nxt_mdiv = mtick ? SASP_PRESC_RST : mdiv_ff + 5'h01;
    nxt_codec_clk = codec_clk_ff;
    nxt_cdiv = cdiv_ff + 5'h01;
    if (cdiv_ff >= cfg.codec_div) begin
      nxt_cdiv = SASP_PRESC_RST;
      nxt_codec_clk = !codec_clk_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mdiv_ff <= SASP_PRESC_RST;
      cdiv_ff <= SASP_PRESC_RST;
      codec_clk_ff <= 1'b0;
    end else begin
      mdiv_ff <= nxt_mdiv;
      cdiv_ff <= nxt_cdiv;
      codec_clk_ff <= nxt_codec_clk;
    end
  end

  // Channel sequencer and sample shifter
  sasp_ch_st_t ch_st_ff, nxt_ch_st;
  logic bclk_ff, nxt_bclk, lrck_ff, nxt_lrck, sdo_ff, nxt_sdo;
  logic primed_ff, nxt_primed;
  logic [SASP_SLOT_W-1:0] cnt_ff, nxt_cnt, last_bit, load_pos;
  logic [SASP_SAMPLE_W-1:0] tx_sh_ff, nxt_tx_sh, rx_sh_ff, nxt_rx_sh;
  logic run, rise_ev, fall_ev, load_ev;

  always_comb begin
    run = cfg.tx_en || cfg.rx_en;
    last_bit = cfg.width16 ? SASP_LAST_BIT16 : SASP_LAST_BIT8;
    load_pos = cfg.msb_just ? SASP_LOAD_POS_MSBJ : SASP_LOAD_POS_I2S;
    nxt_ch_st = ch_st_ff;
    nxt_bclk = bclk_ff;
    nxt_lrck = lrck_ff;
    nxt_cnt = cnt_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_sdo = sdo_ff;
    nxt_primed = primed_ff;
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    load_ev = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_push_data = cfg.width16 ? rx_sh_ff : {8'h00, rx_sh_ff[7:0]};
    case (ch_st_ff)
      CH_IDLE: begin
        nxt_bclk = SASP_BCLK_RST;
        nxt_lrck = SASP_LRCK_RST;
        nxt_cnt = last_bit;
        nxt_primed = 1'b0;
        nxt_sdo = 1'b0;
        if (run) begin
          nxt_ch_st = CH_RUN;
        end
      end
      CH_RUN: begin
        // bit clock toggles on master tick
        if (mtick) begin
          nxt_bclk = !bclk_ff;
          rise_ev = !bclk_ff;
          fall_ev = bclk_ff;
        end
        if (rise_ev) begin
          nxt_rx_sh = {rx_sh_ff[SASP_SAMPLE_W-2:0], sdi};
        end
        if (fall_ev) begin
          if (cnt_ff >= last_bit) begin
            nxt_cnt = '0;
            nxt_lrck = !lrck_ff;
          end else begin
            nxt_cnt = cnt_ff + 4'h1;
          end
          load_ev = (nxt_cnt == load_pos);
          if (load_ev) begin
            tx_pop = cfg.tx_en && !tx_empty;
            nxt_tx_sh = !tx_pop ? '0 : cfg.width16 ? tx_q_data : {tx_q_data[7:0], 8'h00};
            rx_push = cfg.rx_en && primed_ff && !rx_full;
            nxt_primed = 1'b1;
          end else begin
            nxt_tx_sh = {tx_sh_ff[SASP_SAMPLE_W-2:0], 1'b0};
          end
          nxt_sdo = nxt_tx_sh[SASP_SAMPLE_W-1];
        end
        if (!run && fall_ev) begin
          nxt_ch_st = CH_IDLE;
        end
      end
      default: begin
        nxt_ch_st = CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ch_st_ff <= CH_IDLE;
      bclk_ff <= SASP_BCLK_RST;
      lrck_ff <= SASP_LRCK_RST;
      sdo_ff <= 1'b0;
      cnt_ff <= SASP_LAST_BIT16;
      tx_sh_ff <= '0;
      rx_sh_ff <= '0;
      primed_ff <= 1'b0;
    end else begin
      ch_st_ff <= nxt_ch_st;
      bclk_ff <= nxt_bclk;
      lrck_ff <= nxt_lrck;
      sdo_ff <= nxt_sdo;
      cnt_ff <= nxt_cnt;
      tx_sh_ff <= nxt_tx_sh;
      rx_sh_ff <= nxt_rx_sh;
      primed_ff <= nxt_primed;
    end
  end

  assign ser.serial_bit_clock = bclk_ff;
  assign ser.channel_select_clock = lrck_ff;
  assign ser.sdo = sdo_ff;
  assign ser.codec_clock = codec_clk_ff;

  sequence s_rx_served;
    rx_dma_req && rx_dma_ack;
  endsequence

  a_tx_no_room: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (tx_full || !cfg.tx_en) |=> !tx_dma_req)
    else $error("transmit request with no room or disabled");

  a_rx_req_drop: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    s_rx_served |=> !rx_dma_req ##1 !rx_dma_req)
    else $error("receive request not withdrawn after service");

  a_rx_req_data: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(rx_dma_req) |-> $past(bus_st_ff == BF_FETCH) && $past(!rx_empty))
    else $error("receive request without queued data");

  a_bclk_tick: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $changed(ser.serial_bit_clock) && $past(ch_st_ff == CH_RUN) |-> $past(mtick))
    else $error("bit clock moved without master tick");

  a_lr_boundary: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $changed(ser.channel_select_clock) && $past(ch_st_ff == CH_RUN)
      |-> $past(fall_ev) && $past(cnt_ff >= last_bit))
    else $error("select clock moved inside a word");

  a_msbj_load: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    fall_ev && cfg.msb_just && (cnt_ff >= last_bit) |-> load_ev)
    else $error("justified sample not loaded at select change");

  a_i2s_delay: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    fall_ev && !cfg.msb_just && (cnt_ff >= last_bit) |-> !load_ev)
    else $error("inter-IC sample loaded without one bit delay");

  a_shift_msb: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    fall_ev && !load_ev |=> sdo_ff == $past(tx_sh_ff[SASP_SAMPLE_W-2]))
    else $error("shifter did not advance one bit");

  a_codec_div: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $changed(ser.codec_clock) |-> $past(cdiv_ff >= cfg.codec_div))
    else $error("codec clock toggled before prescale count");

  a_dir_gate: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (rx_push |-> cfg.rx_en) and (tx_pop |-> cfg.tx_en))
    else $error("queue moved for a disabled direction");
endmodule

// *** design/sasp_pkg.sv ***
// Shared constants and types for the stereo audio serial port
package sasp_pkg;
  localparam int SASP_FIFO_BYTES = 64;
  localparam int SASP_SAMPLE_W = 16;
  localparam int SASP_FIFO_DEPTH = SASP_FIFO_BYTES / 2;
  localparam int SASP_PRESC_W = 5;
  localparam int SASP_SLOT_W = 4;
  localparam logic [SASP_SLOT_W-1:0] SASP_LAST_BIT16 = 4'hF;
  localparam logic [SASP_SLOT_W-1:0] SASP_LAST_BIT8 = 4'h7;
  localparam logic [SASP_SLOT_W-1:0] SASP_LOAD_POS_I2S = 4'h1;
  localparam logic [SASP_SLOT_W-1:0] SASP_LOAD_POS_MSBJ = 4'h0;
  localparam logic SASP_BCLK_RST = 1'b0;
  localparam logic SASP_LRCK_RST = 1'b0;
  localparam logic [SASP_PRESC_W-1:0] SASP_PRESC_RST = 5'h00;

  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic msb_just;
    logic width16;
    logic [SASP_PRESC_W-1:0] master_div;
    logic [SASP_PRESC_W-1:0] codec_div;
  } sasp_cfg_t;

  typedef struct packed {
    logic serial_bit_clock;
    logic channel_select_clock;
    logic sdo;
    logic codec_clock;
  } sasp_ser_t;
endpackage

// *** design/sasp_fifo.sv ***
// Sample queue with count, used for transmit and receive directions
`timescale 1ns/1ps
module sasp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Fill side
  input wire logic push,
  input wire logic [W-1:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [W-1:0] pop_data,
  // Level
  output logic full,
  output logic empty,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic do_push, do_pop;

  always_comb begin
    do_push = push && (cnt_ff != AW'(0) + (AW+1)'(DEPTH));
    do_pop = pop && (cnt_ff != '0);
    nxt_wr = do_push ? wr_ff + AW'(1) : wr_ff;
    nxt_rd = do_pop ? rd_ff + AW'(1) : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ff] <= push_data;
    end
  end

  assign pop_data = mem[rd_ff];
  assign count = cnt_ff;
  assign full = (cnt_ff == (AW+1)'(DEPTH));
  assign empty = (cnt_ff == '0);

  a_fifo_bound: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    full |=> (count == (AW+1)'(DEPTH)) || $past(pop))
    else $error("queue lost an entry while full");
endmodule

// *** testbench/sasp_codec_model.sv ***
// Behavioural stereo codec on the far side of the serial link
`timescale 1ns/1ps
module sasp_codec_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Link and format
  input wire sasp_pkg::sasp_ser_t ser,
  input wire logic msbj,
  input wire logic w16,
  output logic sdi,
  // Words heard and words sent
  output logic [15:0] cap_word,
  output logic cap_stb,
  output logic [15:0] gen_word,
  output logic gen_stb
);
  import sasp_pkg::*;
  logic pb, ps, pf, started, gen_tgl, gen_seen;
  logic [15:0] sh, o;
  int pos, fpos, w;
  assign w = w16 ? 16 : 8;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {pb, ps, started, cap_stb, gen_stb, gen_seen} <= '0;
      pos = -1;
      sh = '0;
    end else begin
      cap_stb <= 1'b0;
      gen_stb <= (gen_tgl != gen_seen);
      gen_seen <= gen_tgl;
      pb <= ser.serial_bit_clock;
      if (ser.serial_bit_clock && !pb) begin
        sh = {sh[14:0], ser.sdo};
        pos = (ser.channel_select_clock != ps) ? 0 : pos + 1;
        ps <= ser.channel_select_clock;
        // word end by framing and width
        if (msbj ? pos == w - 1 : (pos == 0 && started)) begin
          cap_word <= w16 ? sh : {8'h00, sh[7:0]};
          cap_stb <= 1'b1;
        end
        if (pos == 0) started <= 1'b1;
      end
    end
  end
  // Drive each bit just after the falling bit clock, so even the fastest rate is met
  always @(negedge ser.serial_bit_clock or negedge resetn) begin
    if (!resetn) begin
      pf = 1'b0;
      fpos = 0;
      o = '0;
      sdi <= 1'b0;
      gen_tgl <= 1'b0;
    end else begin
      #0.1;
      fpos = (ser.channel_select_clock != pf) ? 0 : fpos + 1;
      pf = ser.channel_select_clock;
      // new word MSB at slot start, or one bit later for inter-IC framing
      if (fpos == (msbj ? 0 : 1)) begin
        o = w16 ? 16'($urandom) : {8'h00, 8'($urandom)};
        gen_word <= o;
        gen_tgl <= !gen_tgl;
        if (!w16) o = o << 8;
      end else begin
        o = o << 1;
      end
      sdi <= o[15];
    end
  end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the stereo audio serial port
`timescale 1ns/1ps
module tb;
  import sasp_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  sasp_cfg_t cfg = '0;
  logic tx_dma_ack = 1'b0;
  logic rx_dma_ack = 1'b0;
  logic [15:0] tx_dma_data = '0;
  logic tx_dma_req, rx_dma_req, cap_stb, gen_stb, sdi;
  logic [15:0] rx_dma_data, cap_word, gen_word;
  sasp_ser_t ser;
  logic [15:0] txq[$], capq[$], genq[$], rxq[$];
  int mismatches = 0;
  int tests_run = 0;
  initial forever #2 ref_clk = ~ref_clk;
  sasp_top i_dut (.ref_clk, .resetn, .cfg, .tx_dma_req, .tx_dma_ack, .tx_dma_data,
    .rx_dma_req, .rx_dma_ack, .rx_dma_data, .ser, .sdi);
  sasp_codec_model i_codec (.ref_clk, .resetn, .ser, .msbj(cfg.msb_just),
    .w16(cfg.width16), .sdi, .cap_word, .cap_stb, .gen_word, .gen_stb);
  always @(posedge ref_clk) begin
    if (cap_stb) capq.push_back(cap_word);
    if (gen_stb) genq.push_back(gen_word);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [15:0] mk(input logic w16);
    logic [15:0] r;
    r = 16'($urandom) | 16'h0001;
    return w16 ? r : {8'h00, r[7:0]};
  endfunction
  task automatic start(input sasp_cfg_t c);
    resetn <= 1'b0;
    cfg <= c;
    repeat (16) @(posedge ref_clk);
    check(16'({tx_dma_req, rx_dma_req, ser}), 16'h0000, "busy in reset");
    capq.delete();
    genq.delete();
    txq.delete();
    rxq.delete();
    resetn <= 1'b1;
  endtask
  // Word per ack, idle gap so the request level is current
  task automatic feed(input int n, input int bound);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (tx_dma_req !== 1'b1 && k < bound) begin
        @(posedge ref_clk);
        k++;
      end
      if (tx_dma_req !== 1'b1) begin
        if (bound > 1) begin
          mismatches++;
          close_out();
        end
        return;
      end
      txq.push_back(mk(cfg.width16));
      tx_dma_ack <= 1'b1;
      tx_dma_data <= txq[$];
      @(posedge ref_clk);
      tx_dma_ack <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask
  task automatic drain(input int cyc);
    repeat (cyc) begin
      @(posedge ref_clk);
      if (rx_dma_req === 1'b1 && !rx_dma_ack) begin
        rxq.push_back(rx_dma_data);
        rx_dma_ack <= 1'b1;
      end else rx_dma_ack <= 1'b0;
    end
    @(posedge ref_clk);
    rx_dma_ack <= 1'b0;
  endtask
  task automatic period(input bit cc, input int exp);
    logic v;
    int k;
    k = 0;
    v = cc ? ser.codec_clock : ser.serial_bit_clock;
    while ((cc ? ser.codec_clock : ser.serial_bit_clock) === v && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    v = cc ? ser.codec_clock : ser.serial_bit_clock;
    k = 0;
    while ((cc ? ser.codec_clock : ser.serial_bit_clock) === v && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    check(16'(k), 16'(exp), "clock half period");
  endtask
  task automatic stream(input int m);
    sasp_cfg_t c;
    int j;
    c.tx_en = (m != 5);
    c.rx_en = (m != 4);
    c.msb_just = m[0];
    c.width16 = m[1] | (m > 3);
    c.master_div = 5'(m % 4);
    c.codec_div = 5'($urandom_range(31));
    start(c);
    fork
      feed(c.tx_en ? 6 : 0, 3000);
      drain(3000);
    join
    period(1'b0, c.master_div + 1);
    period(1'b1, c.codec_div + 1);
    j = 0;
    while (j < capq.size() && capq[j] === 16'h0000) j++;
    foreach (txq[i]) check(j + i < capq.size() ? capq[j + i] : 16'h0000, txq[i], "tx word");
    if (!c.tx_en) check(16'(tx_dma_req), 16'h0000, "tx request while off");
    check(16'(c.rx_en ? rxq.size() >= 4 : rxq.size() == 0), 16'h0001, "rx count");
    j = 0;
    while (rxq.size() > 0 && j < genq.size() && genq[j] !== rxq[0]) j++;
    foreach (rxq[i]) check(rxq[i], j + i < genq.size() ? genq[j + i] : ~rxq[i], "rx word");
    $display("test %0d done", m);
  endtask
  initial begin
    sasp_cfg_t c;
    void'($urandom(32'hf3a2));
    for (int m = 0; m < 6; m++) stream(m);
    c = '0;
    c.tx_en = 1'b1;
    c.width16 = 1'b1;
    c.master_div = 5'h1F;
    start(c);
    repeat (4) @(posedge ref_clk);
    feed(40, 1);
    check(16'(txq.size() inside {[SASP_FIFO_DEPTH:SASP_FIFO_DEPTH + 1]}), 16'h0001, "fill");
    check(16'(tx_dma_req), 16'h0000, "request when full");
    $display("test fill done");
    close_out();
  end
endmodule
